// *** src/frsc_device.sv ***
// Flash status register, rewrite mode and erase-suspend logic of the device end.
// Assumes the array sequencer reports completion, errors and lock state as pulses.
import frsc_pkg::*;

module frsc_device (
	input  wire logic                       ref_clk_in,
	input  wire logic                       reset_n_in,
	frsc_if.device                          bus,
	input  wire logic [FRSC_BLOCK_BITS-1:0] ctrl_block_in,  // Block holding the rewrite program.
	input  wire logic                       op_done_in,     // Sequencer finished the operation.
	input  wire logic                       op_fail_in,     // Finished operation failed.
	input  wire logic                       lock_state_in,  // Lock state seen by read lock.
	input  wire logic                       stop_done_in,   // Stop or wake sequence finished.
	output wire logic                       op_start_out,   // Start pulse to the sequencer.
	output wire logic                       op_suspend_out  // Suspend pulse to the sequencer.
);

	// ****************************************************************
	// State and flags
	// ****************************************************************
	frsc_state_t state_r;            // Sequencer tracking state.
	frsc_cmd_t   op_r;               // Operation in flight.
	logic [FRSC_BLOCK_BITS-1:0] op_block_r; // Block under rewrite.
	logic        ready_req_r;        // Ready request flag.
	logic        access_err_r;       // Access error request flag.
	logic        lock_mon_r;         // Lock state monitor.
	logic        prog_err_r;         // Program error flag.
	logic        erase_err_r;        // Erase/blank check error flag.
	logic        rd_armed_ready_r;   // Dummy read seen for the ready flag.
	logic        rd_armed_access_r;  // Dummy read seen for the access flag.
	logic [7:0]  status_r;           // Registered read data.
	logic        start_r;
	logic        suspend_r;
	logic        erase_held_r;       // A suspended erase waits behind a program.

	logic cmd_ok;        // Command is accepted this cycle.
	logic cmd_error;     // Command error detected this cycle.
	logic to_ready;      // Busy-to-ready transition this cycle.
	logic suspend_go;    // Suspend entered this cycle.
	logic is_array_op;   // Command needs the array sequencer.
	logic access_hit;    // CPU touched the block under rewrite while busy.
	logic ready_bit;

	// Busy covers every non-ready, non-suspended state, including abort and wake.
	assign ready_bit = (state_r == FRSC_ST_READY) || (state_r == FRSC_ST_SUSPEND);

	// ****************************************************************
	// Command acceptance
	// ****************************************************************
	// Array commands are only taken when idle, or programs while suspended.
	always_comb begin
		is_array_op = (bus.cmd_code != FRSC_CMD_CLEAR_STAT) && (bus.cmd_code != FRSC_CMD_BAD_SEQ);
		cmd_ok = 1'b0;
		cmd_error = 1'b0;
		if (bus.cmd_valid && bus.rewrite_mode_select) begin
			if (bus.cmd_code == FRSC_CMD_BAD_SEQ) begin
				cmd_error = 1'b1;
			end else if (!is_array_op) begin
				cmd_ok = 1'b1;
			end else if (bus.rom_exec_rewrite_mode && bus.cmd_block == ctrl_block_in &&
				(bus.cmd_code == FRSC_CMD_PROGRAM || bus.cmd_code == FRSC_CMD_ERASE)) begin
				cmd_ok = 1'b0;
			end else if (state_r == FRSC_ST_READY) begin
				cmd_ok = 1'b1;
			end else if (state_r == FRSC_ST_SUSPEND && bus.cmd_code == FRSC_CMD_PROGRAM) begin
				cmd_ok = 1'b1;
			end else begin
				cmd_ok = 1'b0;
			end
		end
	end

	// Suspend applies only to a running erase; ROM mode ignores the software request.
	always_comb begin
		suspend_go = 1'b0;
		if (state_r == FRSC_ST_BUSY && op_r == FRSC_CMD_ERASE && bus.suspend_enable &&
			!erase_held_r) begin
			if (bus.irq_suspend_enable && bus.maskable_irq) begin
				suspend_go = 1'b1;
			end else if (!bus.rom_exec_rewrite_mode && bus.suspend_request) begin
				suspend_go = 1'b1;
			end
		end
	end

	// Every return to ready from a busy state counts, whatever the cause.
	assign to_ready = !ready_bit && (
		((state_r == FRSC_ST_BUSY) && (op_done_in || suspend_go)) ||
		((state_r == FRSC_ST_ABORT || state_r == FRSC_ST_WAKE) && stop_done_in));

	assign access_hit = !ready_bit && bus.array_access && bus.array_block == op_block_r;

	// ****************************************************************
	// Sequencer tracking
	// ****************************************************************
	// A program accepted during suspend returns to suspend; the erase restarts once the request and interrupt are low.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= FRSC_ST_READY;
		end else begin
			case (state_r)
				FRSC_ST_READY, FRSC_ST_SUSPEND: begin
					if (bus.flash_stop && state_r == FRSC_ST_READY) begin
						state_r <= FRSC_ST_STOPPED;
					end else if (bus.force_stop && state_r == FRSC_ST_SUSPEND) begin
						state_r <= FRSC_ST_ABORT;
					end else if (cmd_ok && is_array_op) begin
						state_r <= FRSC_ST_BUSY;
					end else if (state_r == FRSC_ST_SUSPEND && !bus.suspend_request &&
						!bus.maskable_irq) begin
						state_r <= FRSC_ST_BUSY; // Erase restart.
					end
				end
				FRSC_ST_BUSY: begin
					if (bus.force_stop) begin
						state_r <= FRSC_ST_ABORT;
					end else if (suspend_go) begin
						state_r <= FRSC_ST_SUSPEND;
					end else if (op_done_in && erase_held_r) begin
						state_r <= FRSC_ST_SUSPEND;
					end else if (op_done_in) begin
						state_r <= FRSC_ST_READY;
					end
				end
				FRSC_ST_ABORT: begin
					if (stop_done_in) begin
						state_r <= FRSC_ST_READY;
					end
				end
				FRSC_ST_STOPPED: begin
					if (!bus.flash_stop) begin
						state_r <= FRSC_ST_WAKE;
					end
				end
				FRSC_ST_WAKE: begin
					if (stop_done_in) begin
						state_r <= FRSC_ST_READY;
					end
				end
				default: state_r <= FRSC_ST_READY;
			endcase
		end
	end

	// The operation started from ready and its block are remembered; a program taken in suspend keeps the erase's.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			op_r       <= FRSC_CMD_PROGRAM;
			op_block_r <= '0;
		end else if (cmd_ok && is_array_op && state_r == FRSC_ST_READY) begin
			op_r       <= bus.cmd_code;
			op_block_r <= bus.cmd_block;
		end
	end

	// A program taken during suspend must return to suspend, not to ready.
	// Without this flag the stalled erase would be lost or suspended twice.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			erase_held_r <= 1'b0;
		end else if (cmd_ok && is_array_op && state_r == FRSC_ST_SUSPEND) begin
			erase_held_r <= 1'b1;
		end else if (state_r == FRSC_ST_BUSY && (op_done_in || bus.force_stop)) begin
			erase_held_r <= 1'b0;
		end
	end

	// Start and suspend pulses to the array sequencer.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			start_r   <= 1'b0;
			suspend_r <= 1'b0;
		end else begin
			start_r   <= cmd_ok && is_array_op;
			suspend_r <= suspend_go;
		end
	end

	// ****************************************************************
	// Interrupt request flags
	// ****************************************************************
	// Dummy reads arm the clear; a write of one never sets a flag.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_armed_ready_r  <= 1'b0;
			rd_armed_access_r <= 1'b0;
		end else if (bus.status_rd) begin
			rd_armed_ready_r  <= ready_req_r;
			rd_armed_access_r <= access_err_r;
		end else if (bus.status_wr) begin
			rd_armed_ready_r  <= 1'b0;
			rd_armed_access_r <= 1'b0;
		end
	end

	// The set term is tested first so an event in the clearing cycle survives.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ready_req_r <= 1'b0;
		end else if (to_ready && bus.ready_irq_enable) begin
			ready_req_r <= 1'b1;
		end else if (bus.status_wr && rd_armed_ready_r && !bus.status_wdata[FRSC_BIT_READY_REQ]) begin
			ready_req_r <= 1'b0;
		end
	end

	// Access errors come from busy accesses and from command failures.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			access_err_r <= 1'b0;
		end else if ((access_hit && bus.access_error_irq_enable) ||
			(bus.command_error_irq_enable && (cmd_error ||
			(state_r == FRSC_ST_BUSY && op_done_in && op_fail_in)))) begin
			access_err_r <= 1'b1;
		end else if ((bus.status_wr && rd_armed_access_r &&
			!bus.status_wdata[FRSC_BIT_ACCESS_ERR]) ||
			(cmd_ok && bus.cmd_code == FRSC_CMD_CLEAR_STAT)) begin
			access_err_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Error and lock flags
	// ****************************************************************
	// Error flags hold until clear status; a command error sets both.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prog_err_r  <= 1'b0;
			erase_err_r <= 1'b0;
		end else if (cmd_error) begin
			prog_err_r  <= 1'b1;
			erase_err_r <= 1'b1;
		end else if (state_r == FRSC_ST_BUSY && op_done_in && op_fail_in) begin
			prog_err_r  <= prog_err_r || op_r == FRSC_CMD_PROGRAM;
			erase_err_r <= erase_err_r || op_r == FRSC_CMD_ERASE ||
				op_r == FRSC_CMD_BLANK_CHECK;
		end else if (cmd_ok && bus.cmd_code == FRSC_CMD_CLEAR_STAT) begin
			prog_err_r  <= 1'b0;
			erase_err_r <= 1'b0;
		end
	end

	// Lock state is captured only as a read lock finishes, then held.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			lock_mon_r <= FRSC_LOCK_MON_RESET;
		end else if (state_r == FRSC_ST_BUSY && op_done_in && op_r == FRSC_CMD_READ_LOCK) begin
			lock_mon_r <= lock_state_in;
		end
	end

	// ****************************************************************
	// Status read data and outputs
	// ****************************************************************
	// Registered one cycle behind the flags; bit three is tied low.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status_r <= FRSC_STATUS_RESET;
		end else begin
			status_r[FRSC_BIT_READY_REQ]  <= ready_req_r;
			status_r[FRSC_BIT_ACCESS_ERR] <= access_err_r;
			status_r[FRSC_BIT_LOCK_MON]   <= lock_mon_r;
			status_r[FRSC_BIT_UNUSED]     <= 1'b0;
			status_r[FRSC_BIT_PROG_ERR]   <= prog_err_r;
			status_r[FRSC_BIT_ERASE_ERR]  <= erase_err_r;
			status_r[FRSC_BIT_SUSPEND]    <= state_r == FRSC_ST_SUSPEND;
			status_r[FRSC_BIT_READY_BUSY] <= ready_bit;
		end
	end

	assign bus.status_rdata    = status_r;
	assign bus.cmd_accepted    = cmd_ok;
	// Holding the CPU in ROM mode keeps its I/O ports frozen.
	assign bus.cpu_hold        = bus.rom_exec_rewrite_mode && state_r == FRSC_ST_BUSY;
	assign bus.read_array_mode = ready_bit;
	assign op_start_out        = start_r;
	assign op_suspend_out      = suspend_r;

endmodule

// *** src/frsc_pkg.sv ***
// Shared constants and types for the flash rewrite status and mode control link.
// Assumes both ends run on one system clock with an active-low asynchronous reset.
package frsc_pkg;

	// ****************************************************************
	// Status register layout
	// ****************************************************************
	localparam logic [15:0] FRSC_STATUS_OFFSET      = 16'h01b2; // Status register address.
	localparam int          FRSC_BIT_READY_REQ      = 0;        // Ready request flag.
	localparam int          FRSC_BIT_ACCESS_ERR     = 1;        // Access error request flag.
	localparam int          FRSC_BIT_LOCK_MON       = 2;        // Lock state monitor.
	localparam int          FRSC_BIT_UNUSED         = 3;        // Unassigned, reads zero.
	localparam int          FRSC_BIT_PROG_ERR       = 4;        // Program error flag.
	localparam int          FRSC_BIT_ERASE_ERR      = 5;        // Erase/blank check error flag.
	localparam int          FRSC_BIT_SUSPEND        = 6;        // Suspend state flag.
	localparam int          FRSC_BIT_READY_BUSY     = 7;        // Ready/busy flag.
	localparam logic [7:0]  FRSC_STATUS_RESET       = 8'h80;    // Ready, all else clear.
	localparam logic        FRSC_LOCK_MON_RESET     = 1'b1;     // Lock monitor after reset.

	// ****************************************************************
	// Commands issued by the CPU side
	// ****************************************************************
	typedef enum logic [2:0] {
		FRSC_CMD_PROGRAM     = 3'h0, // Program one byte.
		FRSC_CMD_ERASE       = 3'h1, // Erase one block.
		FRSC_CMD_LOCK_PROG   = 3'h2, // Program a lock bit.
		FRSC_CMD_READ_LOCK   = 3'h3, // Read lock bit status.
		FRSC_CMD_BLANK_CHECK = 3'h4, // Blank check one block.
		FRSC_CMD_CLEAR_STAT  = 3'h5, // Clear status register.
		FRSC_CMD_BAD_SEQ     = 3'h6  // Malformed sequence, a command error.
	} frsc_cmd_t;

	// Sequencer states of the device end.
	typedef enum logic [2:0] {
		FRSC_ST_READY   = 3'h0, // Idle, read array mode.
		FRSC_ST_BUSY    = 3'h1, // Array operation running.
		FRSC_ST_SUSPEND = 3'h2, // Erase suspended.
		FRSC_ST_ABORT   = 3'h3, // Forced stop in progress.
		FRSC_ST_STOPPED = 3'h4, // Flash stopped.
		FRSC_ST_WAKE    = 3'h5  // Flash starting after stop.
	} frsc_state_t;

	localparam int FRSC_BLOCK_BITS = 2; // Four program ROM blocks.

endpackage

// *** src/frsc_if.sv ***
// Interface joining the CPU-side controller and the flash status logic.
// Assumes a single clock shared by both ends; no tristate pins exist.
interface frsc_if (
	input wire logic clk,
	input wire logic reset_n
);
	import frsc_pkg::*;

	logic                       rewrite_mode_select;   // CPU rewrite mode enabled.
	logic                       rom_exec_rewrite_mode; // 1: ROM-executing mode, 0: RAM-executing.
	logic                       ready_irq_enable;
	logic                       access_error_irq_enable;
	logic                       command_error_irq_enable;
	logic                       suspend_enable;
	logic                       suspend_request;
	logic                       irq_suspend_enable;
	logic                       maskable_irq;          // An enabled maskable interrupt fired.
	logic                       flash_stop;            // Stop request, level.
	logic                       force_stop;            // Forced termination pulse.
	logic                       cmd_valid;             // Command strobe.
	frsc_cmd_t                  cmd_code;
	logic [FRSC_BLOCK_BITS-1:0] cmd_block;
	logic                       cmd_accepted;          // Command taken this cycle.
	logic                       status_rd;             // Status read strobe.
	logic                       status_wr;             // Status write strobe.
	logic [7:0]                 status_wdata;
	logic [7:0]                 status_rdata;          // Registered status.
	logic                       array_access;          // CPU access to the flash array.
	logic [FRSC_BLOCK_BITS-1:0] array_block;
	logic                       cpu_hold;              // CPU held during ROM-mode rewrite.
	logic                       read_array_mode;       // Flash readable as array.

	modport device (
		input  rewrite_mode_select, rom_exec_rewrite_mode, ready_irq_enable,
		input  access_error_irq_enable, command_error_irq_enable,
		input  suspend_enable, suspend_request, irq_suspend_enable, maskable_irq,
		input  flash_stop, force_stop, cmd_valid, cmd_code, cmd_block,
		input  status_rd, status_wr, status_wdata, array_access, array_block,
		output cmd_accepted, status_rdata, cpu_hold, read_array_mode
	);

	modport host (
		output rewrite_mode_select, rom_exec_rewrite_mode, ready_irq_enable,
		output access_error_irq_enable, command_error_irq_enable,
		output suspend_enable, suspend_request, irq_suspend_enable, maskable_irq,
		output flash_stop, force_stop, cmd_valid, cmd_code, cmd_block,
		output status_rd, status_wr, status_wdata, array_access, array_block,
		input  cmd_accepted, status_rdata, cpu_hold, read_array_mode
	);
endinterface

// *** src/frsc_host.sv ***
// CPU-side controller driving the flash status logic from a simple user port.
// Assumes the user keeps commands within user ROM blocks and waits while held.
import frsc_pkg::*;

module frsc_host (
	input  wire logic                       ref_clk_in,
	input  wire logic                       reset_n_in,
	frsc_if.host                            bus,
	input  wire logic [7:0]                 ctrl_in,       // Mode and enable bits, see note.
	input  wire logic                       irq_in,        // Enabled maskable interrupt.
	input  wire logic                       cmd_req_in,    // Command request pulse.
	input  wire frsc_cmd_t                  cmd_code_in,
	input  wire logic [FRSC_BLOCK_BITS-1:0] cmd_block_in,
	input  wire logic                       clear_req_in,  // Clear both request flags.
	input  wire logic                       access_in,     // Array access pulse.
	input  wire logic [FRSC_BLOCK_BITS-1:0] access_block_in,
	output wire logic                       cmd_done_out,  // Command taken.
	output wire logic [7:0]                 status_out,    // Last status seen.
	output wire logic                       held_out       // CPU held.
);

	// ****************************************************************
	// Control register and clear sequence
	// ****************************************************************
	logic [7:0] ctrl_r;   // Mode and enable bits.
	logic [1:0] clr_r;    // Clear sequence: 1 dummy read, 2 write zero.
	logic [7:0] stat_r;   // Captured status.

	// The mode bit only drops when no request flag is pending.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ctrl_r <= 8'h00;
		end else if (!ctrl_in[0] && (bus.status_rdata[FRSC_BIT_READY_REQ] ||
			bus.status_rdata[FRSC_BIT_ACCESS_ERR])) begin
			ctrl_r <= {ctrl_in[7:1], ctrl_r[0]};
		end else begin
			ctrl_r <= ctrl_in;
		end
	end

	// A dummy read always precedes the clearing write.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clr_r <= 2'h0;
		end else if (clr_r == 2'h0 && clear_req_in) begin
			clr_r <= 2'h1;
		end else if (clr_r == 2'h1) begin
			clr_r <= 2'h2;
		end else begin
			clr_r <= 2'h0;
		end
	end

	// Status is sampled every cycle for the user.
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stat_r <= FRSC_STATUS_RESET;
		end else begin
			stat_r <= bus.status_rdata;
		end
	end

	assign bus.rewrite_mode_select      = ctrl_r[0];
	assign bus.rom_exec_rewrite_mode    = ctrl_r[1];
	assign bus.ready_irq_enable         = ctrl_r[2];
	assign bus.access_error_irq_enable  = ctrl_r[3];
	assign bus.command_error_irq_enable = ctrl_r[4];
	assign bus.suspend_enable           = ctrl_r[5];
	assign bus.suspend_request          = ctrl_r[6];
	assign bus.irq_suspend_enable       = ctrl_r[7];
	assign bus.maskable_irq             = irq_in;
	assign bus.flash_stop               = 1'b0;
	assign bus.force_stop               = 1'b0;
	// Commands are dropped while the CPU is held; the block field passes through unchecked.
	assign bus.cmd_valid                = cmd_req_in && !bus.cpu_hold;
	assign bus.cmd_code                 = cmd_code_in;
	assign bus.cmd_block                = cmd_block_in;
	assign bus.status_rd                = clr_r == 2'h1;
	assign bus.status_wr                = clr_r == 2'h2;
	assign bus.status_wdata             = 8'h00;
	assign bus.array_access             = access_in;
	assign bus.array_block              = access_block_in;
	assign cmd_done_out                 = bus.cmd_accepted;
	assign status_out                   = stat_r;
	assign held_out                     = bus.cpu_hold;

endmodule

// *** tb/frsc_chk.sv ***
// Concurrent checks on the host to device flash status link.
// Assumes it watches the interface signals directly, in one clock domain.
module frsc_chk
	import frsc_pkg::*;
(
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       rewrite_mode_select,
	input wire logic       rom_exec_rewrite_mode,
	input wire logic       ready_irq_enable,
	input wire logic       cmd_accepted,
	input wire frsc_cmd_t  cmd_code,
	input wire logic [7:0] status_rdata,
	input wire logic       cpu_hold,
	input wire logic       read_array_mode
);
	// One clock for all checks; reset masks them so stale history never fires.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	chk_bit_three_zero: assert property (!status_rdata[3])
		else $error("status bit three set");
	chk_cmd_needs_mode: assert property (
		cmd_accepted |-> rewrite_mode_select)
		else $error("command taken with rewrite mode off");
	chk_hold_rom_only: assert property (
		cpu_hold |-> rom_exec_rewrite_mode && !read_array_mode)
		else $error("CPU held outside a ROM-mode rewrite");
	chk_array_readable: assert property (
		read_array_mode |=> status_rdata[7])
		else $error("array readable while status shows busy");
	chk_busy_after_cmd: assert property (
		cmd_accepted && cmd_code inside {FRSC_CMD_PROGRAM, FRSC_CMD_ERASE,
		FRSC_CMD_BLANK_CHECK, FRSC_CMD_READ_LOCK} |-> ##2 !status_rdata[7])
		else $error("busy not shown two cycles after a command");
	chk_suspend_is_ready: assert property (
		status_rdata[6] |-> status_rdata[7])
		else $error("suspend shown while busy");
	chk_ready_req_cause: assert property (
		$rose(status_rdata[0]) |-> $past(ready_irq_enable, 2))
		else $error("ready request set while its enable was off");
	chk_ready_req_edge: assert property (
		$rose(status_rdata[0]) |-> $rose(status_rdata[7]))
		else $error("ready request set without a busy to ready change");
	// The main scenarios: commands, suspension and a held CPU.
	cov_cmd: cover property (cmd_accepted);
	cov_suspend: cover property (status_rdata[6]);
	cov_hold: cover property (cpu_hold);
endmodule

// *** tb/test_flash_rewrite_status_control.sv ***
// Bench joining the host and device ends of the flash status link.
// Assumes the device end answers as the hand-over walk describes.
module test_flash_rewrite_status_control;
	timeunit 1ns;
	timeprecision 100ps;
	import frsc_pkg::*;
	logic       ref_clk_in = 1'h0, reset_n_in = 1'h0, irq_in = 1'h0, cmd_req_in = 1'h0;
	logic       clear_req_in = 1'h0, access_in = 1'h0, op_done_in = 1'h0, op_fail_in = 1'h0;
	logic       lock_state_in = 1'h1, ok, done, held;
	logic [7:0] ctrl_in = 8'h00;
	logic [1:0] cmd_block_in = 2'h0, access_block_in = 2'h0;
	frsc_cmd_t  cmd_code_in = FRSC_CMD_PROGRAM;
	int         n_mismatch = 0, n_compared = 0;
	wire  [7:0] st;
	// Free-running 40 MHz system clock.
	always #12.5 ref_clk_in = ~ref_clk_in;
	frsc_if frsc_if_i (.clk(ref_clk_in), .reset_n(reset_n_in));
	assign st = frsc_if_i.status_rdata;
	frsc_host frsc_host_i (.ref_clk_in, .reset_n_in, .bus(frsc_if_i.host), .ctrl_in, .irq_in,
		.cmd_req_in, .cmd_code_in, .cmd_block_in, .clear_req_in, .access_in,
		.access_block_in, .cmd_done_out(done), .status_out(), .held_out(held));
	// Block three holds the rewrite program; the stop path is not exercised.
	frsc_device frsc_device_i (.ref_clk_in, .reset_n_in, .bus(frsc_if_i.device),
		.ctrl_block_in(2'h3), .op_done_in, .op_fail_in, .lock_state_in,
		.stop_done_in(1'h0), .op_start_out(), .op_suspend_out());
	frsc_chk frsc_chk_i (.clk(ref_clk_in), .reset_n(reset_n_in),
		.rewrite_mode_select(frsc_if_i.rewrite_mode_select),
		.rom_exec_rewrite_mode(frsc_if_i.rom_exec_rewrite_mode),
		.ready_irq_enable(frsc_if_i.ready_irq_enable), .cmd_accepted(frsc_if_i.cmd_accepted),
		.cmd_code(frsc_if_i.cmd_code), .status_rdata(st), .cpu_hold(frsc_if_i.cpu_hold),
		.read_array_mode(frsc_if_i.read_array_mode));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk_in);
	endtask
	// Issues one command and watches a bounded window for its acceptance.
	task automatic cmd(input frsc_cmd_t k, input logic [1:0] b);
		cmd_code_in = k;
		cmd_block_in = b;
		cmd_req_in = 1'h1;
		ok = 1'h0;
		for (int i = 0; i < 8; i++) begin
			#12 ok |= (done === 1'h1);
			@(negedge ref_clk_in);
			cmd_req_in = 1'h0;
		end
	endtask
	// The sequencer reports completion as a one-cycle pulse.
	task automatic fin(input logic f);
		op_fail_in = f;
		op_done_in = 1'h1;
		tick(1);
		op_done_in = 1'h0;
		tick(4);
	endtask
	task automatic clr();
		clear_req_in = 1'h1;
		tick(1);
		clear_req_in = 1'h0;
		tick(6);
	endtask
	// Runs one array operation, optionally touching its block while busy.
	task automatic op(input logic [7:0] c, input frsc_cmd_t k, input logic [1:0] b,
		input logic f, input logic acc);
		ctrl_in = c;
		tick(3);
		cmd(k, b);
		check(ok, 8'h1);
		check(st[7], 8'h0);
		check(held, c[1]);
		access_block_in = b;
		access_in = acc;
		tick(1);
		access_in = 1'h0;
		fin(f);
	endtask
	initial begin
		tick(20);
		reset_n_in = 1'h1;
		tick(3);
		check(st, 8'h84);
		ctrl_in = 8'h04;
		cmd(FRSC_CMD_PROGRAM, 2'h1);
		check(ok, 8'h0);
		op(8'h05, FRSC_CMD_PROGRAM, 2'h1, 1'h0, 1'h0);
		check(st, 8'h85);
		clr();
		check(st, 8'h84);
		op(8'h0d, FRSC_CMD_ERASE, 2'h2, 1'h0, 1'h1);
		check(st, 8'h87);
		clr();
		op(8'h15, FRSC_CMD_PROGRAM, 2'h0, 1'h1, 1'h0);
		check(st, 8'h97);
		cmd(FRSC_CMD_CLEAR_STAT, 2'h0);
		tick(2);
		check(st, 8'h85);
		clr();
		op(8'h15, FRSC_CMD_BLANK_CHECK, 2'h0, 1'h1, 1'h0);
		check(st, 8'ha7);
		cmd(FRSC_CMD_CLEAR_STAT, 2'h0);
		cmd(FRSC_CMD_BAD_SEQ, 2'h0);
		tick(4);
		check(st[5:4], 8'h3);
		cmd(FRSC_CMD_CLEAR_STAT, 2'h0);
		clr();
		lock_state_in = 1'h0;
		op(8'h05, FRSC_CMD_READ_LOCK, 2'h0, 1'h0, 1'h0);
		lock_state_in = 1'h1;
		clr();
		check(st, 8'h80);
		ctrl_in = 8'h07;
		tick(1);
		cmd(FRSC_CMD_PROGRAM, 2'h3);
		check(ok, 8'h0);
		op(8'h07, FRSC_CMD_ERASE, 2'h1, 1'h0, 1'h0);
		clr();
		// Suspend by software request in RAM mode, program, then resume.
		ctrl_in = 8'h25;
		tick(3);
		cmd(FRSC_CMD_ERASE, 2'h1);
		ctrl_in = 8'h65;
		tick(4);
		check(st & 8'hfb, 8'hc1);
		cmd(FRSC_CMD_PROGRAM, 2'h2);
		check(ok, 8'h1);
		fin(1'h0);
		ctrl_in = 8'h25;
		tick(4);
		fin(1'h0);
		check(st[7:6], 8'h2);
		clr();
		// ROM mode ignores the software request and needs an interrupt.
		ctrl_in = 8'h67;
		tick(3);
		cmd(FRSC_CMD_ERASE, 2'h1);
		tick(4);
		check(st[6], 8'h0);
		ctrl_in = 8'he7;
		irq_in = 1'h1;
		tick(4);
		check(st[6], 8'h1);
		irq_in = 1'h0;
		ctrl_in = 8'h27;
		tick(4);
		fin(1'h0);
		check(st[7:6], 8'h2);
		wrap_up();
	end
endmodule
